//--- rtl/flash_pkg.sv
// Shared constants, pin carriers and opcodes of the serial flash device
// How it works
// R1: Command, address and write bits are taken on serial clock rising edges.
// R2: Output bits change only on serial clock falling edges.
// R3: A sequence starts only on a falling edge of the active-low select.
// R4: Host holds select low from first to last bit of a sequence.
// R5: Select high means standby: clock and data are ignored, output released.
// R6: Hold pauses the sequence without deselecting or losing its progress.
// R7: Write-protect pin arms or disarms the lock bit of the status byte.
// R8: Clock may idle low or high; both clock modes work.
// R9: Opcode 3b is dual-output fast read, bb is dual in/out fast read.
// R10: Dual modes use both data pins, in on rise, out on fall.
// R11: Array is 256 sectors of 4 KB overlaid by 16 blocks of 64 KB.
// R12: Erase by sector, by block or whole chip.
// R13: Page program writes at most 256 bytes, busy for about 0.8 ms.
// R14: Erase busy about 40 ms sector, 80 ms block, 500 ms chip.
// R15: Host polls status busy bit; device keeps it current.
// R16: Hold enters and leaves only on hold edges while clock is low.
// R17: In hold the output pins are released whatever clock and data do.
// R18: Status write refused when protect pin low and lock bit set.
// R19: Status bit 0 reads 1 while erase or program runs.
// R20: Address bits 19..12 pick sector, 19..16 block; higher bits ignored.
package flash_pkg;
  localparam int CLK_NS = 4;
  localparam int T_PP_NS = 800000;
  localparam int T_SE_NS = 40000000;
  localparam int T_BE_NS = 80000000;
  localparam int T_CE_NS = 500000000;
  localparam int CYC_PP = T_PP_NS / CLK_NS;
  localparam int CYC_SE = T_SE_NS / CLK_NS;
  localparam int CYC_BE = T_BE_NS / CLK_NS;
  localparam int CYC_CE = T_CE_NS / CLK_NS;
  localparam int ADDR_W = 20;
  localparam int SECTOR_LSB = 12;
  localparam int BLOCK_LSB = 16;
  localparam int PAGE_W = 8;
  localparam int N_SECTORS = 256;
  localparam int N_BLOCKS = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [ADDR_W-1:0] SECTOR_MASK = 20'h00fff;
  localparam logic [ADDR_W-1:0] BLOCK_MASK = 20'h0ffff;
  localparam logic [ADDR_W-1:0] CHIP_MASK = 20'hfffff;
  localparam logic [4:0] ADDR_CLK_1 = 5'h18;
  localparam logic [4:0] ADDR_CLK_2 = 5'h0c;
  localparam logic [4:0] DUMMY_FAST = 5'h08;
  localparam logic [4:0] DUMMY_DIO = 5'h04;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] DUAL_LAST = 5'h03;
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_WRITE_STATUS_INSTR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_DREAD = 8'h3b;
  localparam logic [7:0] OP_CE_ALT = 8'h60;
  localparam logic [7:0] OP_DIOREAD = 8'hbb;
  localparam logic [7:0] OP_CE = 8'hc7;
  localparam logic [7:0] OP_BE = 8'hd8;
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP = 2;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] ERASED = 8'hff;
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic hold_n;
    logic wp_n;
    logic [1:0] data;
  } pin_in_t;
  typedef struct packed {
    logic [1:0] data;
    logic [1:0] oe;
  } pin_out_t;
  localparam pin_in_t PIN_IDLE = '{sck: 1'b0, cs_n: 1'b1, hold_n: 1'b1, wp_n: 1'b1, data: 2'h0};
  localparam pin_out_t PIN_OFF = '{data: 2'h0, oe: 2'h0};
endpackage

//--- rtl/byte_fifo.sv
// Show-ahead FIFO with valid/ready on both sides and a synchronous flush
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // DEPTH must be a power of two: the pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [WIDTH-1:0] buf_d [DEPTH];
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Honest flags straight from the fill count
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = buf_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next pointers and storage; flush beats any push or pop
  always_comb
  begin
    buf_d = buf_q;
    rd_d = rd_q;
    wr_d = wr_q;
    cnt_d = cnt_q;
    if (clear)
    begin
      rd_d = '0;
      wr_d = '0;
      cnt_d = '0;
    end
    else
    begin
      if (push)
      begin
        buf_d[wr_q] = in_data;
        wr_d = wr_q + AW'(1);
      end
      if (pop)
        rd_d = rd_q + AW'(1);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    buf_q <= buf_d;
    if (rst)
    begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

//--- rtl/flash_array.sv
// Byte-wide single-port storage array with registered read data
module flash_array #(
  parameter int ABITS = 20,
  parameter int DBITS = 8
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic we,
  input wire logic [ABITS-1:0] addr,
  input wire logic [DBITS-1:0] wdata,
  output logic [DBITS-1:0] rdata_q
);
  logic [DBITS-1:0] mem_q [2**ABITS];

  // Cells keep their contents across reset, like the real array
  always_ff @(posedge clk_sys)
  begin
    if (we)
      mem_q[addr] <= wdata;
    if (rst)
      rdata_q <= '0;
    else
      rdata_q <= mem_q[addr];
  end
endmodule

//--- rtl/spi_flash_dev.sv
// Serial flash device: pin sampling, command sequencer, status and erase engine
module spi_flash_dev #(
  parameter int unsigned PP_CYCLES = flash_pkg::CYC_PP,
  parameter int unsigned SE_CYCLES = flash_pkg::CYC_SE,
  parameter int unsigned BE_CYCLES = flash_pkg::CYC_BE,
  parameter int unsigned CE_CYCLES = flash_pkg::CYC_CE,
  parameter int FIFO_WORDS = flash_pkg::FIFO_DEPTH
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire flash_pkg::pin_in_t pins_in,
  output flash_pkg::pin_out_t pins_out
);
  import flash_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR, S_DUMMY, S_DIN, S_DOUT, S_SKIP} ser_state_t;

  pin_in_t sync1_q, sync2_q, prev_q;
  ser_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [23:0] sh_q, sh_d, nxt1, nxt2;
  logic [7:0] op_q, op_d, byte_q, byte_d, wr_q, wr_d, new_byte, cur, sft, status_byte;
  logic [ADDR_W-1:0] addr_q, addr_d, pf_addr_q, pf_addr_d, wa_q, wa_d, wend_q, wend_d;
  logic [ADDR_W-1:0] er_mask, mem_addr;
  logic hold_q, hold_d, go_q, go_d, wel_q, wel_d, lock_q, lock_d;
  logic [3:0] bp_q, bp_d;
  pin_out_t out_q, out_d;
  logic sel, sck_rise, sck_fall, cs_fall, cs_rise, hold_fall, hold_rise;
  logic dual_in, dual_out, pp_we, pf_load, pop, pp_start, er_start;
  logic [31:0] er_cyc, timer_q, timer_d;
  logic walk_q, walk_d, busy_q, busy_d;
  logic pf_on_q, pf_on_d, pf_pend_q, issue, mem_we, f_in_ready, f_valid;
  logic [7:0] mem_wdata, mem_rdata, f_data;
  logic [2:0] sh_amt;

  // Every pin crosses two flops; only the second stage and its delayed copy are read
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_q <= PIN_IDLE;
      sync2_q <= PIN_IDLE;
      prev_q <= PIN_IDLE;
    end
    else
    begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Edge finders on the sampled pins; the serial clock is just another input
  assign sel = ~sync2_q.cs_n;
  assign sck_rise = sync2_q.sck & ~prev_q.sck;
  assign sck_fall = ~sync2_q.sck & prev_q.sck;
  assign cs_fall = ~sync2_q.cs_n & prev_q.cs_n;
  assign cs_rise = sync2_q.cs_n & ~prev_q.cs_n;
  assign hold_fall = ~sync2_q.hold_n & prev_q.hold_n;
  assign hold_rise = sync2_q.hold_n & ~prev_q.hold_n;
  assign nxt1 = {sh_q[22:0], sync2_q.data[0]};
  assign nxt2 = {sh_q[21:0], sync2_q.data[1], sync2_q.data[0]};
  assign dual_in = op_q == OP_DIOREAD;
  assign dual_out = (op_q == OP_DREAD) || (op_q == OP_DIOREAD); // [R9]
  assign status_byte = {lock_q, 1'b0, bp_q, wel_q, busy_q}; // [R19]
  assign new_byte = (op_q == OP_RDSR) ? status_byte : (f_valid ? f_data : ERASED);
  assign pins_out = out_q;

  // Serial sequencer: decode, address, dummy, data in and data out
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    op_d = op_q;
    addr_d = addr_q;
    byte_d = byte_q;
    wr_d = wr_q;
    go_d = go_q;
    wel_d = wel_q;
    bp_d = bp_q;
    lock_d = lock_q;
    out_d = out_q;
    hold_d = hold_q;
    pp_we = 1'b0;
    pf_load = 1'b0;
    pop = 1'b0;
    pp_start = 1'b0;
    er_start = 1'b0;
    er_cyc = CE_CYCLES;
    er_mask = CHIP_MASK;
    cur = byte_q;
    sft = byte_q;
    sh_amt = 3'h0;
    // Pause and resume only while the clock sits low
    if (!sel)
      hold_d = 1'b0;
    else if (!hold_q && hold_fall && !sync2_q.sck)
      hold_d = 1'b1; // [R16]
    else if (hold_q && hold_rise && !sync2_q.sck)
      hold_d = 1'b0; // [R16]
    // Internal operations other than page-program byte writes start only when the sequence is closed by select going high
    if (cs_rise && go_q)
    begin
      case (op_q)
        OP_WREN: wel_d = 1'b1;
        OP_WRDI: wel_d = 1'b0;
        OP_WRITE_STATUS_INSTR:
        begin
          if (sync2_q.wp_n || !lock_q) // [R7] [R18]
          begin
            lock_d = wr_q[ST_LOCK];
            bp_d = wr_q[ST_BP+3:ST_BP];
          end
          wel_d = 1'b0;
        end
        OP_PP:
        begin
          pp_start = wel_q; // [R13]
          wel_d = 1'b0;
        end
        OP_SE, OP_BE:
        begin
          er_start = wel_q; // [R12]
          er_mask = (op_q == OP_SE) ? SECTOR_MASK : BLOCK_MASK; // [R11] [R20]
          er_cyc = (op_q == OP_SE) ? SE_CYCLES : BE_CYCLES; // [R14]
          wel_d = 1'b0;
        end
        OP_CE, OP_CE_ALT:
        begin
          er_start = wel_q && (bp_q == 4'h0); // [R12]
          wel_d = 1'b0;
        end
        default: ;
      endcase
    end
    if (!sel)
    begin
      state_d = S_IDLE; // [R5]
      go_d = 1'b0;
      out_d.oe = 2'h0; // [R5]
    end
    else if (cs_fall)
    begin
      state_d = S_CMD; // [R3]
      cnt_d = 5'h0;
      op_d = OP_NONE;
      go_d = 1'b0;
    end
    else if (hold_q)
      out_d.oe = 2'h0; // [R6] [R17]
    else
    begin
      case (state_q)
        S_CMD:
        if (sck_rise) // [R1] [R8]
        begin
          sh_d = nxt1;
          cnt_d = cnt_q + 5'h1;
          if (cnt_q == BYTE_LAST)
          begin
            cnt_d = 5'h0;
            op_d = nxt1[7:0];
            state_d = S_SKIP;
            // While busy only the status read is honoured
            if (busy_q && nxt1[7:0] != OP_RDSR)
              op_d = OP_NONE; // [R15]
            else
              case (nxt1[7:0])
                OP_READ, OP_FREAD, OP_DREAD, OP_DIOREAD, OP_PP, OP_SE, OP_BE: state_d = S_ADDR;
                OP_RDSR: state_d = S_DOUT;
                OP_WRITE_STATUS_INSTR: state_d = S_DIN;
                OP_WREN, OP_WRDI, OP_CE, OP_CE_ALT: go_d = 1'b1;
                default: ;
              endcase
          end
        end
        S_ADDR:
        if (sck_rise)
        begin
          sh_d = dual_in ? nxt2 : nxt1; // [R10]
          cnt_d = cnt_q + 5'h1;
          if (cnt_q == (dual_in ? ADDR_CLK_2 : ADDR_CLK_1) - 5'h1)
          begin
            cnt_d = 5'h0;
            addr_d = sh_d[ADDR_W-1:0]; // [R20]
            case (op_q)
              OP_READ:
              begin
                state_d = S_DOUT;
                pf_load = 1'b1;
              end
              OP_PP: state_d = S_DIN;
              OP_SE, OP_BE:
              begin
                state_d = S_SKIP;
                go_d = 1'b1;
              end
              default:
              begin
                state_d = S_DUMMY;
                pf_load = 1'b1;
              end
            endcase
          end
        end
        S_DUMMY:
        if (sck_rise)
        begin
          cnt_d = cnt_q + 5'h1;
          if (cnt_q == (dual_in ? DUMMY_DIO : DUMMY_FAST) - 5'h1)
          begin
            cnt_d = 5'h0;
            state_d = S_DOUT;
          end
        end
        S_DIN:
        if (sck_rise) // [R1]
        begin
          sh_d = nxt1;
          cnt_d = cnt_q + 5'h1;
          if (cnt_q == BYTE_LAST)
          begin
            cnt_d = 5'h0;
            go_d = 1'b1;
            if (op_q == OP_WRITE_STATUS_INSTR)
            begin
              wr_d = nxt1[7:0];
              state_d = S_SKIP;
            end
            else
            begin
              // Bytes past the page end wrap inside the same page
              pp_we = wel_q;
              addr_d = {addr_q[ADDR_W-1:PAGE_W], addr_q[PAGE_W-1:0] + 8'h01}; // [R13]
            end
          end
        end
        S_DOUT:
        if (sck_fall) // [R2] [R8]
        begin
          cur = (cnt_q == 5'h0) ? new_byte : byte_q;
          if (cnt_q == 5'h0)
          begin
            byte_d = new_byte;
            pop = (op_q != OP_RDSR) && f_valid;
          end
          sh_amt = dual_out ? {cnt_q[1:0], 1'b0} : cnt_q[2:0];
          sft = cur << sh_amt;
          out_d.data = dual_out ? sft[7:6] : {sft[7], 1'b0}; // [R10]
          out_d.oe = dual_out ? 2'h3 : 2'h2; // [R10]
          cnt_d = (cnt_q == (dual_out ? DUAL_LAST : BYTE_LAST)) ? 5'h0 : cnt_q + 5'h1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      cnt_q <= 5'h0;
      sh_q <= 24'h0;
      op_q <= OP_NONE;
      addr_q <= '0;
      byte_q <= 8'h0;
      wr_q <= 8'h0;
      go_q <= 1'b0;
      wel_q <= 1'b0;
      bp_q <= 4'h0;
      lock_q <= 1'b0;
      out_q <= PIN_OFF;
      hold_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      op_q <= op_d;
      addr_q <= addr_d;
      byte_q <= byte_d;
      wr_q <= wr_d;
      go_q <= go_d;
      wel_q <= wel_d;
      bp_q <= bp_d;
      lock_q <= lock_d;
      out_q <= out_d;
      hold_q <= hold_d;
    end
  end

  // Busy timer and erase walk; the walk writes one erased byte per cycle
  always_comb
  begin
    timer_d = timer_q;
    walk_d = walk_q;
    wa_d = wa_q;
    wend_d = wend_q;
    if (pp_start)
      timer_d = PP_CYCLES; // [R13]
    else if (er_start)
    begin
      timer_d = er_cyc; // [R14]
      walk_d = 1'b1;
      wa_d = addr_q & ~er_mask; // [R20]
      wend_d = addr_q | er_mask; // [R11]
    end
    else
    begin
      if (timer_q != 32'h0)
        timer_d = timer_q - 32'h1;
      if (walk_q)
      begin
        if (wa_q == wend_q)
          walk_d = 1'b0;
        else
          wa_d = wa_q + ADDR_W'(1);
      end
    end
    busy_d = (timer_d != 32'h0) || walk_d; // [R15] [R19]
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      timer_q <= 32'h0;
      walk_q <= 1'b0;
      wa_q <= '0;
      wend_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      timer_q <= timer_d;
      walk_q <= walk_d;
      wa_q <= wa_d;
      wend_q <= wend_d;
      busy_q <= busy_d;
    end
  end

  // Read prefetch keeps at most one array read in flight, so a granted slot is never lost
  assign issue = pf_on_q & f_in_ready & ~pf_pend_q & ~mem_we;
  always_comb
  begin
    pf_on_d = pf_on_q;
    pf_addr_d = pf_addr_q;
    if (!sel)
      pf_on_d = 1'b0;
    else if (pf_load)
    begin
      pf_on_d = 1'b1;
      pf_addr_d = addr_d;
    end
    else if (issue)
      pf_addr_d = pf_addr_q + ADDR_W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pf_on_q <= 1'b0;
      pf_addr_q <= '0;
      pf_pend_q <= 1'b0;
    end
    else
    begin
      pf_on_q <= pf_on_d;
      pf_addr_q <= pf_addr_d;
      pf_pend_q <= issue & sel;
    end
  end

  // One array port shared by erase walk, page writes and prefetch
  assign mem_we = walk_q | pp_we;
  assign mem_addr = walk_q ? wa_q : (pp_we ? addr_q : pf_addr_q);
  assign mem_wdata = walk_q ? ERASED : sh_d[7:0];

  flash_array #(.ABITS(ADDR_W), .DBITS(8)) u_array (
    .clk_sys(clk_sys),
    .rst(rst),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(~sel),
    .in_valid(pf_pend_q),
    .in_ready(f_in_ready),
    .in_data(mem_rdata),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_pp_go;
    pp_start;
  endsequence
  sequence s_busy_run;
    busy_q [*4];
  endsequence
  property p_r1;
    !sck_rise |=> $stable(sh_q);
  endproperty
  property p_r2;
    $changed(out_q.data) |-> $past(sck_fall);
  endproperty
  property p_r3;
    (state_q == S_IDLE && !cs_fall) |=> state_q == S_IDLE;
  endproperty
  property p_r5;
    !sel |=> (state_q == S_IDLE && out_q.oe == 2'h0);
  endproperty
  property p_r10;
    (sel && !cs_fall && !hold_q && state_q == S_DOUT && sck_fall && dual_out) |=> out_q.oe == 2'h3;
  endproperty
  property p_r13;
    s_pp_go |=> s_busy_run;
  endproperty
  property p_r16;
    $rose(hold_q) |-> $past(hold_fall && !sync2_q.sck);
  endproperty
  property p_r17;
    hold_q |=> out_q.oe == 2'h0;
  endproperty
  property p_r18;
    (cs_rise && go_q && op_q == OP_WRITE_STATUS_INSTR && !sync2_q.wp_n && lock_q)
      |=> $stable({lock_q, bp_q});
  endproperty
  property p_r19;
    // Busy must show in the very next status byte after any program or erase starts
    (pp_start || er_start) |=> status_byte[ST_BUSY];
  endproperty
  property p_r20;
    (er_start && op_q == OP_SE) |=> walk_q && wa_q[SECTOR_LSB-1:0] == '0 && wend_q[SECTOR_LSB-1:0] == '1;
  endproperty
  a_r1: assert property (p_r1) else $error("shift register moved without a clock rise"); // [R1]
  a_r2: assert property (p_r2) else $error("output data changed without a clock fall"); // [R2]
  a_r3: assert property (p_r3) else $error("sequence began without select falling"); // [R3]
  a_r5: assert property (p_r5) else $error("deselected device not in standby"); // [R5]
  a_r10: assert property (p_r10) else $error("dual read did not drive both pins"); // [R10]
  a_r13: assert property (p_r13) else $error("page program not busy"); // [R13]
  a_r16: assert property (p_r16) else $error("hold entered without low clock"); // [R16]
  a_r17: assert property (p_r17) else $error("output driven during hold"); // [R17]
  a_r18: assert property (p_r18) else $error("locked status byte was written"); // [R18]
  a_r19: assert property (p_r19) else $error("busy bit clear during operation"); // [R19]
  a_r20: assert property (p_r20) else $error("sector erase range not aligned"); // [R20]
endmodule

//--- verification/spi_host.sv
// Behavioural SPI host that drives the flash pins and resolves the data wires
module spi_host (
  input wire logic clk_sys,
  input wire flash_pkg::pin_out_t pins_out,
  output flash_pkg::pin_in_t pins_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_pkg::*;
  logic sck = 1'b0;
  logic cs_n = 1'b1;
  logic hold_n = 1'b1;
  logic wp_n = 1'b1;
  logic mode3 = 1'b0;
  logic [1:0] drv = 2'h0;
  logic [1:0] host_oe = 2'h1;
  logic [1:0] last = 2'h0;
  logic [1:0] lvl;
  // A released wire flips every cycle, so a stale bit never passes
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      lvl[i] = (pins_out.oe[i] === 1'b1) ? pins_out.data[i] : (host_oe[i] ? drv[i] : ~last[i]);
  end
  always_ff @(posedge clk_sys)
    last <= lvl;
  assign pins_in = '{sck: sck, cs_n: cs_n, hold_n: hold_n, wp_n: wp_n, data: lvl};
  task automatic half();
    repeat (6) @(negedge clk_sys);
  endtask
  // Clock settles at its idle level before select moves
  task automatic sel();
    sck <= mode3;
    half();
    cs_n <= 1'b0;
    half();
  endtask
  task automatic desel();
    sck <= mode3;
    half();
    cs_n <= 1'b1;
    half();
  endtask
  // Fall lets the device shift, rise samples in both directions
  task automatic clk2(input logic [1:0] d, output logic [1:0] q);
    sck <= 1'b0;
    drv <= d;
    half();
    sck <= 1'b1;
    q = lvl;
    half();
  endtask
  // Byte MSB first; dual moves two bits a clock, high bit on data[1]
  task automatic xfer(input logic [7:0] tx, input logic dual, input logic rcv,
                      output logic [7:0] rx);
    logic [1:0] q;
    host_oe <= dual ? {2{~rcv}} : 2'h1;
    if (dual)
      for (int i = 6; i >= 0; i -= 2)
      begin
        clk2(tx[i+:2], q);
        rx[i+:2] = q;
      end
    else
      for (int i = 7; i >= 0; i--)
      begin
        clk2({1'b0, tx[i]}, q);
        rx[i] = q[1];
      end
  endtask
  // Hold edges only with the clock low; the pulse inside must be ignored
  task automatic pause(output logic [1:0] oe_held);
    sck <= 1'b0;
    half();
    hold_n <= 1'b0;
    half();
    sck <= 1'b1;
    half();
    oe_held = pins_out.oe;
    sck <= 1'b0;
    half();
    hold_n <= 1'b1;
    half();
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the serial flash device driven by a behavioural host
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  pin_in_t pins_in;
  pin_out_t pins_out;
  logic [7:0] rx;
  logic [1:0] oe_held;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  always #2 clk_sys = ~clk_sys;
  // Short busy counts keep the run brief
  spi_flash_dev #(.PP_CYCLES(400), .SE_CYCLES(64), .BE_CYCLES(64), .CE_CYCLES(64))
    spi_flash_dev_inst (.clk_sys(clk_sys), .rst(rst), .pins_in(pins_in), .pins_out(pins_out));
  spi_host spi_host_inst (.clk_sys(clk_sys), .pins_out(pins_out), .pins_in(pins_in));
  task automatic wrap_up();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tx(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
      spi_host_inst.xfer(w[8*i+:8], 1'b0, 1'b0, rx);
  endtask
  task automatic cmd(input logic [31:0] w, input int n);
    spi_host_inst.sel();
    tx(w, n);
    spi_host_inst.desel();
  endtask
  task automatic status(input logic [7:0] exp);
    cmd(32'(OP_RDSR) << 8, 2);
    chk(rx, exp, "status byte");
  endtask
  // Busy must show at least once, then clear within a bounded number of bytes
  task automatic poll();
    int n;
    n = 0;
    spi_host_inst.sel();
    tx(32'(OP_RDSR), 1);
    // The opcode byte reads a floating wire; start the loop as if busy
    rx = 8'h01;
    while (rx[ST_BUSY] !== 1'b0 && n < 1000)
    begin
      spi_host_inst.xfer(8'h00, 1'b0, 1'b0, rx);
      n++;
    end
    spi_host_inst.desel();
    chk(8'(n > 1 && n < 1000), 8'h01, "busy seen then cleared");
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [31:0] e,
                    input int n);
    logic dual;
    logic [31:0] aw;
    dual = (op == OP_DREAD || op == OP_DIOREAD);
    aw = {a, 8'h00};
    spi_host_inst.sel();
    tx(32'(op), 1);
    if (op == OP_DIOREAD)
      for (int i = 3; i >= 0; i--)
        spi_host_inst.xfer(aw[8*i+:8], 1'b1, 1'b0, rx);
    else
      tx(op == OP_READ ? 32'(a) : aw, op == OP_READ ? 3 : 4);
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_host_inst.xfer(8'h00, dual, 1'b1, rx);
      chk(rx, e[8*i+:8], "read data");
    end
    spi_host_inst.desel();
  endtask
  // Clocking while deselected must not latch a command
  task automatic t_standby();
    status(8'h00);
    spi_host_inst.xfer(OP_WREN, 1'b0, 1'b0, rx);
    status(8'h00);
  endtask
  // Erase a sector, program across a page end, read back in every read form
  task automatic t_write_read();
    cmd(32'(OP_WREN), 1);
    cmd({OP_SE, 24'hf12345}, 4);
    poll();
    cmd(32'(OP_WREN), 1);
    spi_host_inst.sel();
    tx({OP_PP, 24'hf123fe}, 4);
    tx(32'ha53c0f, 3);
    spi_host_inst.desel();
    poll();
    rd(OP_READ, 24'h0123fd, 32'hffa53cff, 4);
    rd(OP_FREAD, 24'h012300, 32'h0fff, 2);
    rd(OP_DREAD, 24'h0123fe, 32'ha53c, 2);
    rd(OP_DIOREAD, 24'h0123fe, 32'ha53c, 2);
    spi_host_inst.mode3 = 1'b1;
    rd(OP_READ, 24'h0123ff, 32'h3cff, 2);
    spi_host_inst.mode3 = 1'b0;
  endtask
  // Pause a read between bytes; first bit after resume is lost by design
  task automatic t_hold();
    spi_host_inst.sel();
    tx({OP_READ, 24'h0123fd}, 4);
    tx(32'h0, 1);
    chk(rx, 8'hff, "before hold");
    spi_host_inst.pause(oe_held);
    chk({6'h0, oe_held}, 8'h00, "drive while held");
    tx(32'h0, 1);
    chk(rx & 8'h7f, 8'h25, "resumed byte");
    tx(32'h0, 1);
    chk(rx, 8'h3c, "next byte");
    spi_host_inst.desel();
  endtask
  // Lock bit guards the status byte only while protect is low
  task automatic t_protect();
    cmd(32'({OP_WRITE_STATUS_INSTR, 8'h84}), 2);
    status(8'h84);
    spi_host_inst.wp_n <= 1'b0;
    cmd(32'({OP_WRITE_STATUS_INSTR, 8'h00}), 2);
    status(8'h84);
    cmd(32'(OP_WREN), 1);
    // A refused chip erase still drops the enable latch, and never turns busy
    cmd(32'(OP_CE), 1);
    status(8'h84);
    cmd(32'(OP_WRDI), 1);
    status(8'h84);
    spi_host_inst.wp_n <= 1'b1;
    cmd(32'({OP_WRITE_STATUS_INSTR, 8'h00}), 2);
    status(8'h00);
  endtask
  // Block erase covers the programmed sector
  task automatic t_block();
    cmd(32'(OP_WREN), 1);
    cmd({OP_BE, 24'h01abcd}, 4);
    poll();
    rd(OP_READ, 24'h0123fe, 32'hffff, 2);
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(negedge clk_sys);
    t_standby();
    t_write_read();
    t_hold();
    t_protect();
    t_block();
    wrap_up();
  end
  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 100000)
    begin
      err_count++;
      wrap_up();
    end
  end
endmodule
